// >>> rtl/sleep_wake_reset_cause.sv
// Purpose: Sleep entry, wake-up by reset and reset-cause flags
// Assumes: reset_i is the power-up reset; AHB-Lite slave, single word transfers
// Notes: Wake and watchdog resets are pulsed out on core_reset_o, never on the pin
`timescale 1ns/1ps
module sleep_wake_reset_cause #(
  parameter int WDT_W = sleep_wake_pkg::WDT_WIDTH,
  parameter logic [15:0] WDT_LIMIT = sleep_wake_pkg::WDT_LIMIT_DEF,
  parameter int FILT = sleep_wake_pkg::FILTER_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic sleep_instr_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic master_clear_pin_i,
  input wire logic brown_out_i,
  input wire logic [7:0] second_io_port_i,
  input wire logic [7:0] port_drive_i,
  input wire logic [7:0] port_oe_n_i,
  output logic [7:0] port_drive_o,
  output logic [7:0] port_oe_n_o,
  output logic osc_drive_en_o,
  output logic core_reset_o,
  output logic master_clear_oe_n_o,
  output logic timeout_flag_o,
  output logic powerdown_flag_o,
  output logic pin_change_wake_flag_o
);
  // ----------------------------------------
  // Filtered wake pins
  // ----------------------------------------
  logic [7:0] filt;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_filt
      if (sleep_wake_pkg::MON_MASK[g]) begin : g_on
        pin_glitch_filter #(.FILT(FILT)) u_filt (
          .mclk_i(mclk_i),
          .reset_i(reset_i),
          .ce_i(ce_i),
          .pin_i(second_io_port_i[g]),
          .filt_o(filt[g])
        );
      end else begin : g_off
        // Unwatched pins read as zero
        assign filt[g] = 1'b0;
      end
    end
  endgenerate
  // ----------------------------------------
  // Bus slave state
  // ----------------------------------------
  logic ph_wr;
  logic [7:0] ph_addr;
  logic wdt_en;
  logic pcw_en;
  logic sw_sleep;
  logic sw_wdclr;
  logic [31:0] next_hrdata;
  logic next_ph_wr;
  logic [7:0] next_ph_addr;
  logic next_wdt_en;
  logic next_pcw_en;
  logic next_sw_sleep;
  logic next_sw_wdclr;
  // ----------------------------------------
  // Power state
  // ----------------------------------------
  sleep_wake_pkg::pwr_state_t state;
  sleep_wake_pkg::pwr_state_t next_state;
  logic tof, pdf, pcwf;
  logic next_tof, next_pdf, next_pcwf;
  logic [WDT_W-1:0] wdt_cnt;
  logic [WDT_W-1:0] next_wdt_cnt;
  logic [7:0] snap;
  logic [7:0] next_snap;
  logic [7:0] hold_drv, hold_oe_n;
  logic [7:0] next_hold_drv, next_hold_oe_n;
  logic [2:0] rst_cnt;
  logic [2:0] next_rst_cnt;
  logic master_clear_pin_q;
  logic do_sleep, do_clr, wdt_to, pin_chg, master_clear_pin_fall;
  // ----------------------------------------
  // Wake and command decode
  // ----------------------------------------
  always_comb begin
    do_sleep = sleep_instr_i | sw_sleep;
    do_clr = watchdog_clear_instr_i | sw_wdclr;
    wdt_to = wdt_en && (wdt_cnt == WDT_LIMIT[WDT_W-1:0]);
    pin_chg = pcw_en && (((filt ^ snap) & sleep_wake_pkg::MON_MASK) != 8'h00);
    // Edge, not level, so a pin held low cannot wake twice
    master_clear_pin_fall = master_clear_pin_q & ~master_clear_pin_i;
  end
  // ----------------------------------------
  // Bus slave next state
  // ----------------------------------------
  always_comb begin
    next_ph_wr = 1'b0;
    next_ph_addr = ph_addr;
    next_hrdata = hrdata_o;
    next_wdt_en = wdt_en;
    next_pcw_en = pcw_en;
    next_sw_sleep = 1'b0;
    next_sw_wdclr = 1'b0;
    if (hsel_i && hready_i && htrans_i[1]) begin
      next_ph_wr = hwrite_i;
      next_ph_addr = haddr_i[7:0];
    end
    if (ph_wr && ph_addr == sleep_wake_pkg::CTRL_OFS) begin
      next_wdt_en = hwdata_i[sleep_wake_pkg::CTRL_WDT_EN_BIT];
      next_pcw_en = hwdata_i[sleep_wake_pkg::CTRL_PCW_EN_BIT];
      next_sw_sleep = hwdata_i[sleep_wake_pkg::CTRL_SLEEP_BIT];
      next_sw_wdclr = hwdata_i[sleep_wake_pkg::CTRL_WDCLR_BIT];
    end
    if (hsel_i && hready_i && htrans_i[1] && !hwrite_i) begin
      // Captured in the address phase, shown in the data phase
      case (haddr_i[7:0])
        sleep_wake_pkg::CTRL_OFS: begin
          next_hrdata = 32'h00000000;
          next_hrdata[sleep_wake_pkg::CTRL_WDT_EN_BIT] = next_wdt_en;
          next_hrdata[sleep_wake_pkg::CTRL_PCW_EN_BIT] = next_pcw_en;
        end
        sleep_wake_pkg::STAT_OFS: begin
          next_hrdata = 32'h00000000;
          next_hrdata[sleep_wake_pkg::PCWF_BIT] = pcwf;
          next_hrdata[sleep_wake_pkg::TOF_BIT] = tof;
          next_hrdata[sleep_wake_pkg::PDF_BIT] = pdf;
          next_hrdata[sleep_wake_pkg::ASLEEP_BIT] = (state == sleep_wake_pkg::ST_SLEEP);
        end
        sleep_wake_pkg::WDT_OFS: next_hrdata = 32'(wdt_cnt);
        sleep_wake_pkg::PINS_OFS: next_hrdata = {16'h0000, snap, filt};
        default: next_hrdata = 32'h00000000;
      endcase
    end
  end
  // ----------------------------------------
  // Power state and reset-cause flags
  // ----------------------------------------
  // Time-out outranks sleep so a runaway core cannot dodge the watchdog
  always_comb begin
    next_state = state;
    next_tof = tof;
    next_pdf = pdf;
    next_pcwf = pcwf;
    next_wdt_cnt = wdt_en ? wdt_cnt + 1'b1 : wdt_cnt;
    next_snap = snap;
    next_hold_drv = hold_drv;
    next_hold_oe_n = hold_oe_n;
    next_rst_cnt = (rst_cnt != 3'd0) ? rst_cnt - 3'd1 : 3'd0;
    case (state)
      sleep_wake_pkg::ST_RUN: begin
        if (wdt_to) begin
          next_tof = 1'b0;
          next_wdt_cnt = '0;
          next_rst_cnt = 3'(sleep_wake_pkg::RST_PULSE_CYC);
        end else if (do_sleep) begin
          next_state = sleep_wake_pkg::ST_SLEEP;
          next_tof = 1'b1;
          next_pdf = 1'b0;
          next_pcwf = 1'b1;
          next_wdt_cnt = '0;
          next_snap = filt;
          next_hold_drv = port_drive_i;
          next_hold_oe_n = port_oe_n_i;
        end else if (do_clr) begin
          next_wdt_cnt = '0;
          next_tof = 1'b1;
          next_pdf = 1'b1;
        end
      end
      sleep_wake_pkg::ST_SLEEP: begin
        if (wdt_to || pin_chg || master_clear_pin_fall || brown_out_i) begin
          next_state = sleep_wake_pkg::ST_WAKE;
          next_wdt_cnt = '0;
          next_rst_cnt = 3'(sleep_wake_pkg::RST_PULSE_CYC);
          if (wdt_to) begin
            next_tof = 1'b0;
          end else if (pin_chg) begin
            next_pcwf = 1'b0;
          end
          // Master clear keeps tof=1, pdf=0 from sleep entry
          // Brown-out keeps the flags, whose value is undefined there
        end
      end
      sleep_wake_pkg::ST_WAKE: begin
        // Count held at zero until the core leaves reset
        next_wdt_cnt = '0;
        if (rst_cnt == 3'd1) begin
          next_state = sleep_wake_pkg::ST_RUN;
        end
      end
      default: next_state = sleep_wake_pkg::ST_RUN;
    endcase
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ph_wr <= 1'b0;
      ph_addr <= 8'h00;
      hrdata_o <= 32'h00000000;
      wdt_en <= sleep_wake_pkg::CTRL_WDT_EN_RST;
      pcw_en <= sleep_wake_pkg::CTRL_PCW_EN_RST;
      sw_sleep <= 1'b0;
      sw_wdclr <= 1'b0;
    end else if (ce_i) begin
      ph_wr <= next_ph_wr;
      ph_addr <= next_ph_addr;
      hrdata_o <= next_hrdata;
      wdt_en <= next_wdt_en;
      pcw_en <= next_pcw_en;
      sw_sleep <= next_sw_sleep;
      sw_wdclr <= next_sw_wdclr;
    end
  end
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= sleep_wake_pkg::ST_RUN;
      tof <= 1'b1;
      pdf <= 1'b1;
      pcwf <= 1'b1;
      wdt_cnt <= '0;
      snap <= 8'h00;
      hold_drv <= 8'h00;
      hold_oe_n <= 8'hFF;
      rst_cnt <= 3'd0;
      master_clear_pin_q <= 1'b1;
    end else if (ce_i) begin
      state <= next_state;
      tof <= next_tof;
      pdf <= next_pdf;
      pcwf <= next_pcwf;
      wdt_cnt <= next_wdt_cnt;
      snap <= next_snap;
      hold_drv <= next_hold_drv;
      hold_oe_n <= next_hold_oe_n;
      rst_cnt <= next_rst_cnt;
      master_clear_pin_q <= master_clear_pin_i;
    end
  end
  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      port_drive_o <= 8'h00;
      port_oe_n_o <= 8'hFF;
      osc_drive_en_o <= 1'b1;
      core_reset_o <= 1'b1;
      master_clear_oe_n_o <= 1'b1;
      timeout_flag_o <= 1'b1;
      powerdown_flag_o <= 1'b1;
      pin_change_wake_flag_o <= 1'b1;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else if (ce_i) begin
      // Live pins while running, frozen copy while asleep
      port_drive_o <= (next_state == sleep_wake_pkg::ST_RUN) ? port_drive_i
                                                             : next_hold_drv;
      port_oe_n_o <= (next_state == sleep_wake_pkg::ST_RUN) ? port_oe_n_i
                                                            : next_hold_oe_n;
      osc_drive_en_o <= (next_state != sleep_wake_pkg::ST_SLEEP);
      core_reset_o <= (next_rst_cnt != 3'd0);
      // Pin never driven: a watchdog reset stays inside the chip
      master_clear_oe_n_o <= 1'b1;
      timeout_flag_o <= next_tof;
      powerdown_flag_o <= next_pdf;
      pin_change_wake_flag_o <= next_pcwf;
      // Zero wait states and always OKAY
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end
endmodule : sleep_wake_reset_cause

// >>> rtl/sleep_wake_pkg.sv
// Purpose: Constants for the sleep, wake and reset-cause block
// Assumes: 50 MHz core clock
// Notes: Register map is the AHB-Lite slave view of the block
package sleep_wake_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] WDT_OFS = 8'h08;
  localparam logic [7:0] PINS_OFS = 8'h0C;
  // ----------------------------------------
  // Control fields (write side)
  // ----------------------------------------
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_WDCLR_BIT = 1;
  localparam int CTRL_WDT_EN_BIT = 2;
  localparam int CTRL_PCW_EN_BIT = 3;
  // ----------------------------------------
  // Status fields, STATUS<7>, <4>, <3>, <0>
  // ----------------------------------------
  localparam int PCWF_BIT = 7;
  localparam int TOF_BIT = 4;
  localparam int PDF_BIT = 3;
  localparam int ASLEEP_BIT = 0;
  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic CTRL_WDT_EN_RST = 1'b0;
  localparam logic CTRL_PCW_EN_RST = 1'b0;
  localparam int CLK_MHZ = 50;
  localparam int FILTER_NS = 100;
  localparam int FILTER_CYC = (FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int WDT_WIDTH = 16;
  localparam logic [15:0] WDT_LIMIT_DEF = 16'hFFFF;
  localparam int RST_PULSE_CYC = 4;
  localparam int MON_PINS = 5;
  localparam logic [7:0] MON_MASK = 8'h8F;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAKE = 3'b100
  } pwr_state_t;
endpackage : sleep_wake_pkg

// >>> rtl/pin_glitch_filter.sv
// Purpose: Glitch filter for one wake pin
// Assumes: Input synchronous to mclk_i
// Notes: Output changes only after input is stable for FILT cycles
`timescale 1ns/1ps
module pin_glitch_filter #(
  parameter int FILT = 5
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic pin_i,
  output logic filt_o
);
  // ----------------------------------------
  // Stability counter
  // ----------------------------------------
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic next_filt;
  always_comb begin
    next_cnt = cnt;
    next_filt = filt_o;
    if (pin_i == filt_o) begin
      next_cnt = 8'h00;
    end else if (cnt >= 8'(FILT - 1)) begin
      next_cnt = 8'h00;
      next_filt = pin_i;
    end else begin
      next_cnt = cnt + 8'h01;
    end
  end
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= 8'h00;
      filt_o <= 1'b0;
    end else if (ce_i) begin
      cnt <= next_cnt;
      filt_o <= next_filt;
    end
  end
endmodule : pin_glitch_filter

// >>> bench/sleep_wake_monitor.sv
// Purpose: Checker on the sleep, wake and reset-cause ports
// Assumes: Bound to the top module, one clock domain
// Notes: Watches design outputs plus the ce_i, sleep and watchdog clear inputs
`timescale 1ns/1ps
module sleep_wake_monitor (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic sleep_instr_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic [7:0] port_drive_o,
  input wire logic [7:0] port_oe_n_o,
  input wire logic osc_drive_en_o,
  input wire logic core_reset_o,
  input wire logic master_clear_oe_n_o,
  input wire logic timeout_flag_o,
  input wire logic powerdown_flag_o,
  input wire logic pin_change_wake_flag_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  logic run;
  assign run = osc_drive_en_o & ~core_reset_o & ce_i;
  property p_sleep;
    run && sleep_instr_i && !watchdog_clear_instr_i |=> pin_change_wake_flag_o
      && timeout_flag_o && !powerdown_flag_o && !osc_drive_en_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
  property p_wdclr;
    run && watchdog_clear_instr_i && !sleep_instr_i |=> timeout_flag_o && powerdown_flag_o;
  endproperty
  a_wdclr: assert property (p_wdclr) else $error("watchdog clear flags wrong");
  property p_asleep;
    !osc_drive_en_o |-> !powerdown_flag_o;
  endproperty
  a_asleep: assert property (p_asleep) else $error("clock off while awake");
  property p_hold;
    !osc_drive_en_o |=> $stable(port_drive_o) && $stable(port_oe_n_o);
  endproperty
  a_hold: assert property (p_hold) else $error("pins moved while asleep");
  property p_pin_keep;
    $fell(pin_change_wake_flag_o) |-> $stable(timeout_flag_o) && $stable(powerdown_flag_o);
  endproperty
  a_pin_keep: assert property (p_pin_keep) else $error("pin wake touched flags");
  property p_tof_keep;
    $fell(timeout_flag_o) |-> $stable(powerdown_flag_o) && $stable(pin_change_wake_flag_o);
  endproperty
  a_tof_keep: assert property (p_tof_keep) else $error("time-out touched flags");
  property p_tof_src;
    $rose(timeout_flag_o) |-> $past(watchdog_clear_instr_i) || $past(sleep_instr_i);
  endproperty
  a_tof_src: assert property (p_tof_src) else $error("timeout flag set by no cause");
  property p_pin_off;
    master_clear_oe_n_o;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("master clear pin driven");
  property p_wake_rst;
    $rose(osc_drive_en_o) |-> core_reset_o [*4];
  endproperty
  a_wake_rst: assert property (p_wake_rst) else $error("wake without reset");
endmodule : sleep_wake_monitor
bind sleep_wake_reset_cause sleep_wake_monitor u_mon (.mclk_i, .reset_i, .ce_i,
  .sleep_instr_i, .watchdog_clear_instr_i, .port_drive_o, .port_oe_n_o, .osc_drive_en_o,
  .core_reset_o, .master_clear_oe_n_o, .timeout_flag_o, .powerdown_flag_o,
  .pin_change_wake_flag_o);

// >>> bench/core_pins_model.sv
// Purpose: Core-side pin drive feeding the pin-hold path
// Assumes: Core runs off mclk_i
// Notes: Pattern moves every cycle so a stale hold shows
`timescale 1ns/1ps
module core_pins_model (
  input wire logic mclk_i,
  input wire logic reset_i,
  output logic [7:0] drive_o,
  output logic [7:0] oe_n_o
);
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      drive_o <= 8'h00;
      oe_n_o <= 8'hFF;
    end else begin
      drive_o <= drive_o + 8'h01;
      oe_n_o <= ~drive_o;
    end
  end
endmodule : core_pins_model

// >>> bench/sleep_wake_reset_cause_test.sv
// Purpose: Self-checking bench for the sleep, wake and reset-cause block
// Assumes: 50 MHz clock, watchdog limit cut to 0x0010
// Notes: Outputs sampled 1 ns after the edge; bus read data sampled at the edge
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module sleep_wake_reset_cause_test;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, slp = 1'b0, wdc = 1'b0, pin_n = 1'b1, bo = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic [7:0] io = 8'h00, drv, oen, pdo, pd_o, oe_o, oeo;
  logic hready, hresp, osc, crst, mc_oe_n, tof, pdf, pcwf;
  int errors = 0, checked = 0, cyc = 0;
  always #10 mclk_i = ~mclk_i;
  core_pins_model u_core (.mclk_i, .reset_i, .drive_o(drv), .oe_n_o(oen));
  sleep_wake_reset_cause #(.WDT_LIMIT(16'h0010)) u_dut (.mclk_i, .reset_i, .ce_i(1'b1),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .sleep_instr_i(slp), .watchdog_clear_instr_i(wdc),
    .master_clear_pin_i(pin_n), .brown_out_i(bo), .second_io_port_i(io),
    .port_drive_i(drv), .port_oe_n_i(oen), .port_drive_o(pd_o), .port_oe_n_o(oe_o),
    .osc_drive_en_o(osc), .core_reset_o(crst), .master_clear_oe_n_o(mc_oe_n),
    .timeout_flag_o(tof), .powerdown_flag_o(pdf), .pin_change_wake_flag_o(pcwf));
  task tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk_i); while (hready !== 1'b1);
    rd = hrdata;
    #1;
  endtask : bus
  task pulse(input logic s);
    @(posedge mclk_i);
    if (s) slp <= 1'b1; else wdc <= 1'b1;
    @(posedge mclk_i);
    slp <= 1'b0;
    wdc <= 1'b0;
    #1;
  endtask : pulse
  // Bounded wait for the clock to come back
  task wake;
    for (int i = 0; i < 100 && osc !== 1'b1; i++) tick(1);
  endtask : wake
  task test_done;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    `CHK("flags", 3'b111, {pcwf, tof, pdf});
    bus(1'b0, sleep_wake_pkg::STAT_OFS, 32'h0);
    `CHK("stat", 32'h0000_0098, rd);
    `CHK("hresp", 1'b0, hresp);
    bus(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0000_0000, rd);
    $display("t_reset done");
  endtask : t_reset
  task t_master_clear_pin;
    pulse(1'b1);
    `CHK("osc", 1'b0, osc);
    `CHK("flags", 3'b110, {pcwf, tof, pdf});
    pdo = pd_o;
    oeo = oe_o;
    bus(1'b0, sleep_wake_pkg::STAT_OFS, 32'h0);
    `CHK("stat", 32'h0000_0091, rd);
    `CHK("hold", pdo, pd_o);
    `CHK("hold oe", oeo, oe_o);
    @(posedge mclk_i) pin_n <= 1'b0;
    wake;
    `CHK("crst", 1'b1, crst);
    `CHK("flags", 3'b110, {pcwf, tof, pdf});
    @(posedge mclk_i) pin_n <= 1'b1;
    tick(6);
    `CHK("flags", 3'b110, {pcwf, tof, pdf});
    $display("t_master_clear_pin done");
  endtask : t_master_clear_pin
  task t_wdt;
    bus(1'b1, sleep_wake_pkg::CTRL_OFS, 32'h0000_0004);
    pulse(1'b0);
    `CHK("flags", 2'b11, {tof, pdf});
    // Cleared on the clear edge, one count by the address phase
    bus(1'b0, sleep_wake_pkg::WDT_OFS, 32'h0);
    `CHK("wdt", 32'h0000_0001, rd);
    for (int i = 0; i < 100 && tof !== 1'b0; i++) tick(1);
    `CHK("flags", 2'b01, {tof, pdf});
    `CHK("crst", 1'b1, crst);
    `CHK("pin oe", 1'b1, mc_oe_n);
    pulse(1'b1);
    `CHK("flags", 2'b10, {tof, pdf});
    wake;
    `CHK("osc", 1'b1, osc);
    `CHK("flags", 2'b00, {tof, pdf});
    bus(1'b1, sleep_wake_pkg::CTRL_OFS, 32'h0);
    $display("t_wdt done");
  endtask : t_wdt
  task t_pin;
    bus(1'b1, sleep_wake_pkg::CTRL_OFS, 32'h0000_0008);
    pulse(1'b1);
    // Bits 4 to 6 are not watched
    @(posedge mclk_i) io <= 8'h70;
    tick(20);
    `CHK("osc", 1'b0, osc);
    @(posedge mclk_i) io <= 8'hF0;
    wake;
    `CHK("osc", 1'b1, osc);
    `CHK("flags", 3'b010, {pcwf, tof, pdf});
    bus(1'b0, sleep_wake_pkg::PINS_OFS, 32'h0);
    `CHK("pins", 32'h0000_0080, rd);
    $display("t_pin done");
  endtask : t_pin
  task t_brown;
    tick(10);
    // Sleep and pin-change wake enable from the bus this time
    bus(1'b1, sleep_wake_pkg::CTRL_OFS, 32'h0000_0009);
    tick(3);
    `CHK("osc", 1'b0, osc);
    `CHK("flags", 3'b110, {pcwf, tof, pdf});
    @(posedge mclk_i) bo <= 1'b1;
    wake;
    `CHK("osc", 1'b1, osc);
    @(posedge mclk_i) bo <= 1'b0;
    bus(1'b1, sleep_wake_pkg::CTRL_OFS, 32'h0000_000A);
    tick(2);
    `CHK("flags", 2'b11, {tof, pdf});
    $display("t_brown done");
  endtask : t_brown
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      errors++;
      test_done;
    end
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    tick(2);
    t_reset;
    t_master_clear_pin;
    t_wdt;
    t_pin;
    t_brown;
    test_done;
  end
endmodule : sleep_wake_reset_cause_test
